// >>> hdl/timer16_capture.sv
// Notes on behaviour
// RULE_01: Counter is 16 bits, cleared, counted up or down per timer tick.
// RULE_02: High location is staging; low read/write moves high byte.
// RULE_03: Clock select zero stops counting; counter stays accessible.
// RULE_04: Processor counter write beats any clear or count that cycle.
// RULE_05: Overflow flag set at the mode's point; may raise interrupt.
// RULE_06: Shared upper byte may be written once; guard from interrupts.
// RULE_07: Matching edge on trigger copies whole counter into capture.
// RULE_08: Capture flag sets in the same cycle as the copy.
// RULE_09: Enabled flag requests interrupt; cleared by service or one write.
// RULE_10: Capture low read loads staging; high read returns staging.
// RULE_11: Capture writable only in its top modes; high byte first.
// RULE_12: Capture pin is default trigger; comparator when selected.
// RULE_13: Software clears capture flag after switching trigger source.
// RULE_14: Triggers share counter pin sampling; filter adds four cycles.
// RULE_15: Filter and edge detector idle only in capture-top modes.
// RULE_16: Driving the capture pin by software may trigger a capture.
// RULE_17: Filter output changes only after four equal samples.
// RULE_18: Filter enabled in control B; samples on the system clock.
// RULE_19: Every new capture overwrites the capture register.
// RULE_20: For duty cycle, flip edge after read, then clear flag.
// RULE_21: Avoid capturing while the top value is changing.
// RULE_22: One staging byte is shared by all wide registers.
// RULE_23: Wide writes high byte first; wide reads low byte first.
// RULE_24: Edge select chooses rising or falling trigger transition.
// RULE_25: After reset counter stopped, capture zero, flags clear.
`timescale 1ns/10ps
`include "timer16_defs.svh"

module timer16_capture (
  // System
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  // Processor data bus
  input  wire logic [3:0] ADDR_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  input  wire logic [7:0] WDATA_I,
  output logic      [7:0] RDATA_O,
  // Interrupt requests and service acknowledges
  input  wire logic       OVF_ACK_I,
  input  wire logic       CAP_ACK_I,
  output logic            OVF_IRQ_O,
  output logic            CAP_IRQ_O,
  // Timer clock sources
  input  wire logic [3:0] PRESC_TICK_I,
  input  wire logic       EXTERNAL_COUNT_PIN_I,
  // Capture triggers
  input  wire logic       CAPTURE_PIN_I,
  input  wire logic       COMPARATOR_OUTPUT_I
);
  import timer16_pkg::*;

  state_t      s_reg;
  state_t      s_next;
  logic [3:0]  mode;
  logic [15:0] top;
  logic        dual;
  logic        fast;
  logic        icr_top;
  logic        tick;
  logic        trig_raw;
  logic        edge_in;
  logic        cap_evt;
  logic        ovf_evt;
  logic        wr_cnt_l;
  logic        rd_cnt_l;
  logic        wr_cap_l;
  logic        rd_cap_l;
  logic        wr_flags;
  logic        filt_agree;
  logic [3:0]  filt_win;

  assign mode     = {s_reg.mode_hi, s_reg.mode_lo};
  assign wr_cnt_l = WR_I && (ADDR_I == `T16_CNT_L);
  assign rd_cnt_l = RD_I && (ADDR_I == `T16_CNT_L);
  assign wr_cap_l = WR_I && (ADDR_I == `T16_CAP_L);
  assign rd_cap_l = RD_I && (ADDR_I == `T16_CAP_L);
  assign wr_flags = WR_I && (ADDR_I == `T16_FLAGS);

  // Mode decode: top value, slope and use of the capture register
  always_comb begin
    top     = `T16_MAX;
    dual    = 1'b0;
    fast    = 1'b0;
    icr_top = 1'b0;
    unique case (mode)
      4'h1: begin
        top  = `T16_TOP_8;
        dual = 1'b1;
      end
      4'h2: begin
        top  = `T16_TOP_9;
        dual = 1'b1;
      end
      4'h3: begin
        top  = `T16_TOP_10;
        dual = 1'b1;
      end
      4'h5: begin
        top  = `T16_TOP_8;
        fast = 1'b1;
      end
      4'h6: begin
        top  = `T16_TOP_9;
        fast = 1'b1;
      end
      4'h7: begin
        top  = `T16_TOP_10;
        fast = 1'b1;
      end
      4'h8, 4'ha: begin
        top     = s_reg.cap;
        dual    = 1'b1;
        icr_top = 1'b1;
      end
      4'hc: begin
        top     = s_reg.cap;
        icr_top = 1'b1;
      end
      4'he: begin
        top     = s_reg.cap;
        fast    = 1'b1;
        icr_top = 1'b1;
      end
      // Compare-register tops are not in this block; they run to MAX
      4'h9, 4'hb: dual = 1'b1;
      4'hf:       fast = 1'b1;
      default: ;
    endcase
  end

  // Timer clock selection, one-cycle tick
  always_comb begin
    unique case (clk_sel_t'(s_reg.clk_sel))
      CLK_STOP:  tick = 1'b0; // see RULE_03
      CLK_SYS:   tick = 1'b1;
      CLK_PRE_A: tick = PRESC_TICK_I[0];
      CLK_PRE_B: tick = PRESC_TICK_I[1];
      CLK_PRE_C: tick = PRESC_TICK_I[2];
      CLK_PRE_D: tick = PRESC_TICK_I[3];
      CLK_EXT_F: tick = s_reg.ext_prev & ~s_reg.ext_sync[1];
      CLK_EXT_R: tick = ~s_reg.ext_prev & s_reg.ext_sync[1];
    endcase
  end

  // Pin level only is seen, so port-driven pin levels capture too
  assign trig_raw = s_reg.cmp_sel ? COMPARATOR_OUTPUT_I // see RULE_12
                                  : CAPTURE_PIN_I;     // see RULE_16
  // Newest sample joins three held ones, so the delay stays at four
  assign filt_win   = {s_reg.filt_sh[2:0], s_reg.trig_sync[1]};
  assign filt_agree = (filt_win == 4'hf) || (filt_win == 4'h0);
  assign edge_in = s_reg.noise ? s_reg.filt       // see RULE_17
                               : s_reg.trig_sync[1];
  assign cap_evt = !icr_top                          // see RULE_15
                && (edge_in != s_reg.edge_prev)
                && (edge_in == s_reg.edge_sel);      // see RULE_24

  // Overflow point: MAX for normal/clear, TOP for fast, BOTTOM for dual
  always_comb begin
    if (dual) begin
      ovf_evt = tick && s_reg.down && (s_reg.cnt == 16'h0001);
    end else if (fast) begin
      ovf_evt = tick && (s_reg.cnt == top);
    end else begin
      ovf_evt = tick && (s_reg.cnt == `T16_MAX);
    end
  end

  always_comb begin
    s_next = s_reg;

    // Same sampling path as the external count pin
    s_next.ext_sync  = {s_reg.ext_sync[0], EXTERNAL_COUNT_PIN_I};
    s_next.ext_prev  = s_reg.ext_sync[1];
    s_next.trig_sync = {s_reg.trig_sync[0], trig_raw}; // see RULE_14

    // Filter and edge detector freeze while capture holds the top
    if (!icr_top) begin
      s_next.filt_sh = filt_win; // see RULE_18
      if (filt_agree) begin
        s_next.filt = s_reg.trig_sync[1]; // see RULE_17
      end
      s_next.edge_prev = edge_in;
    end

    // Counter sequence
    if (tick) begin
      if (!dual) begin
        s_next.down = 1'b0;
        if (s_reg.cnt == top) begin
          s_next.cnt = `T16_BOTTOM; // see RULE_01
        end else begin
          s_next.cnt = s_reg.cnt + 16'h0001;
        end
      end else if (!s_reg.down) begin
        if (s_reg.cnt >= top) begin
          s_next.down = 1'b1;
          s_next.cnt  = s_reg.cnt - 16'h0001;
        end else begin
          s_next.cnt = s_reg.cnt + 16'h0001;
        end
      end else if (s_reg.cnt == `T16_BOTTOM) begin
        s_next.down = 1'b0;
        s_next.cnt  = s_reg.cnt + 16'h0001;
      end else begin
        s_next.cnt = s_reg.cnt - 16'h0001;
      end
    end

    // Processor writes; a counter write overrides the sequence
    if (WR_I) begin
      unique case (ADDR_I)
        `T16_CTRL_A: s_next.mode_lo = WDATA_I[`T16_A_MODE_LSB +: 2];
        `T16_CTRL_B: begin
          s_next.clk_sel  = WDATA_I[`T16_B_CLK_LSB +: 3];
          s_next.mode_hi  = WDATA_I[`T16_B_MODE_LSB +: 2];
          s_next.edge_sel = WDATA_I[`T16_B_EDGE];
          s_next.noise    = WDATA_I[`T16_B_NOISE]; // see RULE_18
        end
        `T16_CNT_H, `T16_CAP_H: s_next.temp = WDATA_I; // see RULE_22
        `T16_CNT_L: s_next.cnt = {s_reg.temp, WDATA_I}; // see RULE_04
        `T16_CAP_L: begin
          if (icr_top) begin
            s_next.cap = {s_reg.temp, WDATA_I}; // see RULE_11
          end
        end
        `T16_MASK: begin
          s_next.ovf_en = WDATA_I[`T16_F_OVF];
          s_next.cap_en = WDATA_I[`T16_F_CAP];
        end
        `T16_CMP_CTRL: s_next.cmp_sel = WDATA_I[`T16_CMP_SEL];
        default: ;
      endcase
    end

    // Low-byte reads load the staging byte
    if (rd_cnt_l) begin
      s_next.temp = s_reg.cnt[15:8]; // see RULE_02
    end
    if (rd_cap_l) begin
      s_next.temp = s_reg.cap[15:8]; // see RULE_10
    end

    // Flags: clear by writing one or by service, a new event wins
    if ((wr_flags && WDATA_I[`T16_F_OVF]) || OVF_ACK_I) begin
      s_next.ovf_f = 1'b0;
    end
    if ((wr_flags && WDATA_I[`T16_F_CAP]) || CAP_ACK_I) begin
      s_next.cap_f = 1'b0; // see RULE_09
    end
    if (ovf_evt && !wr_cnt_l) begin
      s_next.ovf_f = 1'b1; // see RULE_05
    end
    if (cap_evt) begin
      s_next.cap   = s_reg.cnt; // see RULE_07, RULE_19
      s_next.cap_f = 1'b1;      // see RULE_08
    end

    s_next.ovf_irq = s_next.ovf_f && s_next.ovf_en;
    s_next.cap_irq = s_next.cap_f && s_next.cap_en; // see RULE_09

    // Read data is registered, valid the cycle after the strobe
    s_next.rdata = 8'h00;
    if (RD_I) begin
      unique case (ADDR_I)
        `T16_CTRL_A: s_next.rdata = {6'h00, s_reg.mode_lo};
        `T16_CTRL_B: s_next.rdata = {s_reg.noise, s_reg.edge_sel, 1'b0,
                                     s_reg.mode_hi, s_reg.clk_sel};
        `T16_CNT_L:  s_next.rdata = s_reg.cnt[7:0];
        `T16_CAP_L:  s_next.rdata = s_reg.cap[7:0];
        `T16_CNT_H, `T16_CAP_H: s_next.rdata = s_reg.temp;
        `T16_FLAGS:  s_next.rdata = {2'h0, s_reg.cap_f, 4'h0, s_reg.ovf_f};
        `T16_MASK:   s_next.rdata = {2'h0, s_reg.cap_en, 4'h0, s_reg.ovf_en};
        `T16_CMP_CTRL: s_next.rdata = {5'h00, s_reg.cmp_sel, 2'h0};
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s_reg <= '0; // see RULE_25
    end else begin
      s_reg <= s_next;
    end
  end

  assign RDATA_O   = s_reg.rdata;
  assign OVF_IRQ_O = s_reg.ovf_irq;
  assign CAP_IRQ_O = s_reg.cap_irq;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  a_stop_holds_count: assert property ( // see RULE_03
    s_reg.clk_sel == 3'h0 && !wr_cnt_l |=> $stable(s_reg.cnt)
  ) else $error("counter moved with clock stopped");

  a_write_beats_count: assert property ( // see RULE_04
    wr_cnt_l && tick
    |=> s_reg.cnt == {$past(s_reg.temp), $past(WDATA_I)}
  ) else $error("counter write lost to count");

  a_low_read_stage: assert property ( // see RULE_02
    rd_cnt_l ##1 (RD_I && ADDR_I == `T16_CNT_H && !WR_I)
    |=> RDATA_O == $past(s_reg.cnt[15:8], 2)
  ) else $error("counter high byte not staged");

  a_capture_copy: assert property ( // see RULE_07
    cap_evt |=> s_reg.cap == $past(s_reg.cnt) && s_reg.cap_f
  ) else $error("capture did not copy counter with flag");

  a_capture_irq: assert property ( // see RULE_09
    cap_evt && s_reg.cap_en |=> CAP_IRQ_O
  ) else $error("capture interrupt not raised");

  a_flag_clear: assert property ( // see RULE_09
    wr_flags && WDATA_I[`T16_F_CAP] && !cap_evt |=> !s_reg.cap_f
  ) else $error("capture flag not cleared by one write");

  a_cap_read_only: assert property ( // see RULE_11
    wr_cap_l && !icr_top && !cap_evt |=> $stable(s_reg.cap)
  ) else $error("capture written outside top modes");

  a_cap_read_stage: assert property ( // see RULE_10
    rd_cap_l && !WR_I |=> s_reg.temp == $past(s_reg.cap[15:8])
  ) else $error("capture high byte not staged");

  a_no_capture_top: assert property ( // see RULE_15
    icr_top |-> !cap_evt ##1 $stable(s_reg.edge_prev)
  ) else $error("capture logic active in capture-top mode");

  a_filter_agree: assert property ( // see RULE_17
    s_reg.filt != $past(s_reg.filt)
    |-> s_reg.filt_sh == {4{s_reg.filt}}
  ) else $error("filter changed without four equal samples");

  a_normal_wrap: assert property ( // see RULE_05
    mode == 4'h0 && tick && s_reg.cnt == `T16_MAX && !WR_I
    |=> s_reg.ovf_f && s_reg.cnt == `T16_BOTTOM
  ) else $error("normal overflow missed");

  a_reset_state: assert property ( // see RULE_25
    $past(RST_I) |-> s_reg.cnt == `T16_CNT_RST
                  && s_reg.cap == `T16_CAP_RST
                  && !s_reg.cap_f && !s_reg.ovf_f
  ) else $error("reset state wrong");

endmodule

// >>> hdl/timer16_defs.svh
`ifndef TIMER16_DEFS_SVH
`define TIMER16_DEFS_SVH

// Byte locations on the processor data bus
`define T16_CTRL_A     4'h0
`define T16_CTRL_B     4'h1
`define T16_CNT_L      4'h2
`define T16_CNT_H      4'h3
`define T16_CAP_L      4'h4
`define T16_CAP_H      4'h5
`define T16_FLAGS      4'h6
`define T16_MASK       4'h7
`define T16_CMP_CTRL   4'h8

// Field positions
`define T16_A_MODE_LSB 0
`define T16_B_CLK_LSB  0
`define T16_B_MODE_LSB 3
`define T16_B_EDGE     6
`define T16_B_NOISE    7
`define T16_F_OVF      0
`define T16_F_CAP      5
`define T16_CMP_SEL    2

// Reset values
`define T16_CNT_RST    16'h0000
`define T16_CAP_RST    16'h0000

// Counter limits
`define T16_TOP_8      16'h00ff
`define T16_TOP_9      16'h01ff
`define T16_TOP_10     16'h03ff
`define T16_MAX        16'hffff
`define T16_BOTTOM     16'h0000

// Noise filter depth in system clock samples
`define T16_FILT_N     4

`endif

// >>> hdl/timer16_pkg.sv
package timer16_pkg;

  typedef enum logic [2:0] {
    CLK_STOP  = 3'h0,
    CLK_SYS   = 3'h1,
    CLK_PRE_A = 3'h2,
    CLK_PRE_B = 3'h3,
    CLK_PRE_C = 3'h4,
    CLK_PRE_D = 3'h5,
    CLK_EXT_F = 3'h6,
    CLK_EXT_R = 3'h7
  } clk_sel_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [7:0]  temp;
    logic [1:0]  mode_lo;
    logic [1:0]  mode_hi;
    logic [2:0]  clk_sel;
    logic        edge_sel;
    logic        noise;
    logic        cmp_sel;
    logic        ovf_f;
    logic        cap_f;
    logic        ovf_en;
    logic        cap_en;
    logic        down;
    logic [1:0]  ext_sync;
    logic        ext_prev;
    logic [1:0]  trig_sync;
    logic [3:0]  filt_sh;
    logic        filt;
    logic        edge_prev;
    logic [7:0]  rdata;
    logic        ovf_irq;
    logic        cap_irq;
  } state_t;

endpackage

// >>> testbench/cpu_bus_model.sv
`timescale 1ns/10ps
`include "timer16_defs.svh"

module cpu_bus_model (
  // System
  input  wire logic       clk_i,
  // Processor data bus
  output logic      [3:0] addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] wdata_o,
  output logic            rd_valid_o
);
  logic slow = 1'b0;

  initial begin
    addr_o = 4'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end

  // Read data is valid the cycle after the strobe is taken
  always_ff @(posedge clk_i) begin
    rd_valid_o <= rd_o;
  end

  task automatic put(input logic w, input logic r, input logic [3:0] a,
                     input logic [7:0] d);
    @(negedge clk_i);
    wr_o = w;
    rd_o = r;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
  endtask

  task automatic idle(input int n);
    repeat (n) put(1'b0, 1'b0, 4'h0, ~wdata_o);
  endtask

  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    put(1'b1, 1'b0, a, d);
    idle(1);
  endtask

  task automatic rd8(input logic [3:0] a);
    put(1'b0, 1'b1, a, 8'h00);
    idle(1);
  endtask

  // Callers keep other staging users out until the low byte lands
  task automatic write_word(input logic [3:0] lo, input logic [15:0] v);
    put(1'b1, 1'b0, lo + 4'h1, v[15:8]);
    if (slow) idle(1);
    put(1'b1, 1'b0, lo, v[7:0]);
    idle(1);
  endtask

  task automatic read_word(input logic [3:0] lo);
    put(1'b0, 1'b1, lo, 8'h00);
    if (slow) idle(1);
    put(1'b0, 1'b1, lo + 4'h1, 8'h00);
    idle(1);
  endtask

  // A source or edge change can itself capture, so the flag goes after
  task automatic retrigger(input logic [3:0] a, input logic [7:0] d);
    wr8(a, d);
    wr8(`T16_FLAGS, 8'h20);
  endtask
endmodule

// >>> testbench/timer16_counter_input_capture_bench.sv
`timescale 1ns/10ps
`include "timer16_defs.svh"

module timer16_counter_input_capture_bench;
  import timer16_pkg::*;

  logic        clk;
  logic        rst;
  logic        ovf_ack;
  logic        cap_ack;
  logic        ext_pin;
  logic        cap_pin;
  logic        cmp_out;
  logic [3:0]  tick;
  logic [3:0]  addr;
  logic        wr;
  logic        rd;
  logic        rd_valid;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        ovf_irq;
  logic        cap_irq;
  logic [7:0]  exp_q[$];
  int          error_cnt = 0;
  int          num_checks = 0;
  int          t_plain;
  int          t_filt;
  logic [15:0] v;

  cpu_bus_model cpu (
    .clk_i      (clk),
    .addr_o     (addr),
    .wr_o       (wr),
    .rd_o       (rd),
    .wdata_o    (wdata),
    .rd_valid_o (rd_valid)
  );

  timer16_capture dut (
    .CLK_I                (clk),
    .RST_I                (rst),
    .ADDR_I               (addr),
    .WR_I                 (wr),
    .RD_I                 (rd),
    .WDATA_I              (wdata),
    .RDATA_O              (rdata),
    .OVF_ACK_I            (ovf_ack),
    .CAP_ACK_I            (cap_ack),
    .OVF_IRQ_O            (ovf_irq),
    .CAP_IRQ_O            (cap_irq),
    .PRESC_TICK_I         (tick),
    .EXTERNAL_COUNT_PIN_I (ext_pin),
    .CAPTURE_PIN_I        (cap_pin),
    .COMPARATOR_OUTPUT_I  (cmp_out)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic rd1(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cpu.rd8(a);
  endtask

  task automatic rdw(input logic [3:0] lo, input logic [15:0] e);
    exp_q.push_back(e[7:0]);
    exp_q.push_back(e[15:8]);
    cpu.read_word(lo);
  endtask

  // Longer than the filtered trigger path, so the event has landed
  task automatic drive(ref logic s, input logic val);
    @(negedge clk);
    s = val;
    repeat (12) @(negedge clk);
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic ticks(input int n, input logic [3:0] m);
    repeat (n) begin
      @(negedge clk);
      tick = m;
      @(negedge clk);
      tick = 4'h0;
    end
  endtask

  task automatic time_to_irq(output int n);
    n = 0;
    while (cap_irq !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 50) begin
        check(16'(n), 16'h0000);
        report_and_stop();
      end
    end
  endtask

  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() > 0) begin
        check({8'h00, rdata}, {8'h00, exp_q.pop_front()});
      end else begin
        check({8'h00, rdata}, 16'hdead);
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    ovf_ack = 1'b0;
    cap_ack = 1'b0;
    ext_pin = 1'b0;
    cap_pin = 1'b0;
    cmp_out = 1'b0;
    tick = 4'h0;
    v = 16'($urandom(88));
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rdw(`T16_CNT_L, `T16_CNT_RST);
    rdw(`T16_CAP_L, `T16_CAP_RST);
    rd1(`T16_FLAGS, 8'h00);
    rd1(4'hf, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = 16'($urandom);
      cpu.slow = i[0];
      cpu.write_word(`T16_CNT_L, v);
      rdw(`T16_CNT_L, v);
    end
    // High byte staged once, then only the low byte written
    cpu.wr8(`T16_CNT_H, 8'hab);
    cpu.wr8(`T16_CNT_L, 8'h01);
    rdw(`T16_CNT_L, 16'hab01);
    rd1(`T16_CAP_L, 8'h00);
    rd1(`T16_CNT_H, 8'h00);
    cpu.write_word(`T16_CNT_L, 16'h1234);
    cpu.wr8(`T16_CTRL_B, 8'h40);
    drive(cap_pin, 1'b1);
    rdw(`T16_CAP_L, 16'h1234);
    rd1(`T16_FLAGS, 8'h20);
    cpu.write_word(`T16_CNT_L, 16'h5678);
    drive(cap_pin, 1'b0);
    rdw(`T16_CAP_L, 16'h1234);
    cpu.retrigger(`T16_CTRL_B, 8'h00);
    rd1(`T16_FLAGS, 8'h00);
    drive(cap_pin, 1'b1);
    drive(cap_pin, 1'b0);
    rdw(`T16_CAP_L, 16'h5678);
    cpu.retrigger(`T16_CMP_CTRL, 8'h04);
    cpu.write_word(`T16_CNT_L, 16'h0777);
    drive(cap_pin, 1'b1);
    drive(cap_pin, 1'b0);
    rd1(`T16_FLAGS, 8'h00);
    drive(cmp_out, 1'b1);
    drive(cmp_out, 1'b0);
    rdw(`T16_CAP_L, 16'h0777);
    cpu.retrigger(`T16_CMP_CTRL, 8'h00);
    // Latency with and without the filter, seen at the interrupt pin
    cpu.wr8(`T16_MASK, 8'h21);
    cpu.wr8(`T16_CTRL_B, 8'h40);
    @(negedge clk);
    cap_pin = 1'b1;
    time_to_irq(t_plain);
    pulse(cap_ack);
    repeat (2) @(negedge clk);
    check(cap_irq, 1'b0);
    drive(cap_pin, 1'b0);
    cpu.wr8(`T16_CTRL_B, 8'hc0);
    repeat (12) @(negedge clk);
    @(negedge clk);
    cap_pin = 1'b1;
    repeat (3) @(negedge clk);
    cap_pin = 1'b0;
    repeat (12) @(negedge clk);
    rd1(`T16_FLAGS, 8'h00);
    @(negedge clk);
    cap_pin = 1'b1;
    time_to_irq(t_filt);
    check(16'(t_filt - t_plain), 16'd4);
    cpu.wr8(`T16_FLAGS, 8'h20);
    check(cap_irq, 1'b0);
    // Capture defines the top here; no capture is expected meanwhile
    cpu.wr8(`T16_CTRL_B, 8'h18);
    cpu.write_word(`T16_CAP_L, 16'h2468);
    drive(cap_pin, 1'b0);
    drive(cap_pin, 1'b1);
    rdw(`T16_CAP_L, 16'h2468);
    rd1(`T16_FLAGS, 8'h00);
    cpu.wr8(`T16_CTRL_B, 8'h00);
    cpu.write_word(`T16_CAP_L, 16'h1111);
    rdw(`T16_CAP_L, 16'h2468);
    cpu.wr8(`T16_CTRL_B, 8'h01);
    cpu.write_word(`T16_CNT_L, 16'h1000);
    cpu.wr8(`T16_CTRL_B, 8'h00);
    rdw(`T16_CNT_L, 16'h1002);
    for (int s = 2; s < 8; s++) begin
      cpu.write_word(`T16_CNT_L, 16'h0000);
      cpu.wr8(`T16_CTRL_B, 8'(s));
      if (s < 6) begin
        ticks(1, 4'(1 << (s - 2)));
      end else begin
        drive(ext_pin, 1'b1);
        drive(ext_pin, 1'b0);
      end
      repeat (4) @(negedge clk);
      cpu.wr8(`T16_CTRL_B, 8'h00);
      rdw(`T16_CNT_L, 16'h0001);
    end
    cpu.write_word(`T16_CNT_L, 16'hfffe);
    cpu.wr8(`T16_CTRL_B, 8'h02);
    ticks(2, 4'h1);
    repeat (2) @(negedge clk);
    check(ovf_irq, 1'b1);
    rd1(`T16_FLAGS, 8'h01);
    pulse(ovf_ack);
    rd1(`T16_FLAGS, 8'h00);
    // Dual slope, 8-bit top: turns round at the top
    cpu.write_word(`T16_CNT_L, 16'h00fe);
    cpu.wr8(`T16_CTRL_A, 8'h01);
    ticks(3, 4'h1);
    cpu.wr8(`T16_CTRL_B, 8'h00);
    rdw(`T16_CNT_L, 16'h00fd);
    cpu.idle(4);
    check(16'(exp_q.size()), 16'h0000);
    report_and_stop();
  end
endmodule
